/* File: src/supervisor_watchdog_reset_defs.vh */
`ifndef SUPERVISOR_WATCHDOG_RESET_DEFS_VH
`define SUPERVISOR_WATCHDOG_RESET_DEFS_VH

// ------------------------------------------------------------
// clock and timing
// ------------------------------------------------------------
// system clock period in ns (20 MHz)
`define SWR_CLK_NS 50
// 2.67 us per pF of timing setting, kept in ns
`define SWR_NS_PER_PF 2670
// extended mode multiplier
`define SWR_EXT_MULT 500
// internal keepalive pulse point, percent of period
`define SWR_KEEPALIVE_PCT 94
// percent base for the keepalive point
`define SWR_PCT_BASE 100

// ------------------------------------------------------------
// register offsets (byte addresses)
// ------------------------------------------------------------
`define SWR_OFS_CTRL 4'h0
`define SWR_OFS_WDT_SET 4'h4
`define SWR_OFS_RST_SET 4'h8
`define SWR_OFS_STATUS 4'hC

// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
// ctrl: output polarity, 1 = active high
`define SWR_CTRL_POL_HIGH 0
// ctrl: output drive, 1 = push-pull
`define SWR_CTRL_PUSH_PULL 1
// status bits
`define SWR_ST_RESET 0
`define SWR_ST_WD_CAUSE 1
`define SWR_ST_EXT_MODE 2
`define SWR_ST_UNDRIVEN 3
`define SWR_ST_UNDERVOLT 4
`define SWR_ST_WD_OFF 5
// status: watchdog event count field
`define SWR_ST_EVT_LSB 8
`define SWR_ST_EVT_MSB 15

// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define SWR_CTRL_RST 2'h0
// 1500 pF for both timing settings
`define SWR_WDT_SET_RST 16'h05DC
`define SWR_RST_SET_RST 16'h05DC

`endif

/* File: src/pin_sync.v */
`timescale 1ns/1ps

// two-stage synchroniser with an edge flag taken after it
module pin_sync (
  input wire sys_clk,
  input wire sys_rst,
  input wire din,
  output reg level,
  output wire toggled
);

  reg meta_q;
  reg last_q;

  // ------------------------------------------------------------
  // synchroniser and history
  // ------------------------------------------------------------
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      meta_q <= 1'b0;
      level <= 1'b0;
      last_q <= 1'b0;
    end else begin
      meta_q <= din;
      level <= meta_q;
      last_q <= level;
    end
  end

  // either edge, compared on settled samples only
  assign toggled = level ^ last_q;

endmodule

/* File: src/supervisor_watchdog_reset.v */
// Chosen here: the Avalon-MM register port and the placing of the registers.
`timescale 1ns/1ps
`include "supervisor_watchdog_reset_defs.vh"

// How it works
// - watchdog period from setting, 2.67us/pF
// - zero watchdog setting disables watchdog
// - mode high multiplies period by 500
// - mode-select change zeroes watchdog count
// - kick or mode edge restarts timer
// - timer held clear while reset asserted
// - extended mode, undriven kick: no timeout
// - undervoltage asserts reset, held while present
// - reset held one timeout after undervoltage
// - expiry gives one reset timeout pulse
// - pulses repeat until a kick edge
// - polarity and open-drain/push-pull selectable
// - power-up holds reset until voltage good
// - reset timeout from setting, 2.67us/pF
// - internal keepalive at 94% of period
module supervisor_watchdog_reset (
  input wire sys_clk,
  input wire sys_rst,
  input wire [3:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  output reg [31:0] avs_readdata,
  output reg avs_waitrequest,
  input wire watchdog_kick_input,
  input wire watchdog_mode_select,
  input wire kick_undriven,
  input wire undervoltage,
  output reg reset_out,
  output reg reset_out_oe_n
);

  // ------------------------------------------------------------
  // states of the reset sequencer
  // ------------------------------------------------------------
  localparam [1:0] ST_HOLD = 2'b00;
  localparam [1:0] ST_PULSE = 2'b01;
  localparam [1:0] ST_RUN = 2'b10;

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  // cycles for a setting in pF, never below one
  function [31:0] cycles_of;
    input [15:0] pf;
    reg [31:0] ns;
    begin
      ns = {16'h0000, pf} * `SWR_NS_PER_PF;
      cycles_of = ns / `SWR_CLK_NS;
      if (cycles_of == 32'h0000_0000) begin
        cycles_of = 32'h0000_0001;
      end
    end
  endfunction

  // ------------------------------------------------------------
  // declarations
  // ------------------------------------------------------------
  reg [1:0] ctrl_q;
  reg [15:0] wdt_set_q;
  reg [15:0] rst_set_q;
  reg [1:0] state_q;
  reg [1:0] state_d;
  reg [31:0] wd_cnt_q;
  reg [31:0] wd_cnt_d;
  reg [31:0] rp_cnt_q;
  reg [31:0] rp_cnt_d;
  reg [31:0] wd_period_q;
  reg [31:0] keepalive_q;
  reg [31:0] rp_period_q;
  reg wd_cause_q;
  reg wd_cause_d;
  reg [7:0] evt_cnt_q;
  reg [31:0] rd_mux;
  wire kick_edge;
  wire mode_lvl;
  wire mode_edge;
  wire undriven_lvl;
  wire uv_lvl;
  wire wd_off;
  wire wd_expire;
  wire wd_keepalive;
  wire asserted_d;
  wire bus_req;
  wire bus_done;

  // ------------------------------------------------------------
  // input synchronisers
  // ------------------------------------------------------------
  // kick edges found
  pin_sync u_kick_sync (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .din(watchdog_kick_input),
    .level(),
    .toggled(kick_edge)
  );

  pin_sync u_mode_sync (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .din(watchdog_mode_select),
    .level(mode_lvl),
    .toggled(mode_edge)
  );

  pin_sync u_undriven_sync (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .din(kick_undriven),
    .level(undriven_lvl),
    .toggled()
  );

  pin_sync u_uv_sync (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .din(undervoltage),
    .level(uv_lvl),
    .toggled()
  );

  // ------------------------------------------------------------
  // period computation
  // ------------------------------------------------------------
  // periods refreshed every cycle from the settings
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      wd_period_q <= 32'h0000_0001;
      keepalive_q <= 32'h0000_0001;
      rp_period_q <= 32'h0000_0001;
    end else begin
      if (mode_lvl) begin
        wd_period_q <= cycles_of(wdt_set_q) * `SWR_EXT_MULT;
      end else begin
        wd_period_q <= cycles_of(wdt_set_q);
      end
      keepalive_q <= (wd_period_q / `SWR_PCT_BASE) * `SWR_KEEPALIVE_PCT;
      rp_period_q <= cycles_of(rst_set_q);
    end
  end

  // ------------------------------------------------------------
  // watchdog conditions
  // ------------------------------------------------------------
  // grounded setting disables
  assign wd_off = (wdt_set_q == 16'h0000);

  // internal driver clears timer before expiry
  assign wd_keepalive = mode_lvl && undriven_lvl && !wd_off &&
                        (wd_cnt_q >= keepalive_q);

  assign wd_expire = !wd_off && !wd_keepalive &&
                     (wd_cnt_q >= wd_period_q - 32'h0000_0001);

  // ------------------------------------------------------------
  // reset sequencer, next state
  // ------------------------------------------------------------
  always @* begin
    state_d = state_q;
    rp_cnt_d = rp_cnt_q;
    wd_cause_d = wd_cause_q;
    case (state_q)
      ST_HOLD: begin
        rp_cnt_d = 32'h0000_0000;
        if (!uv_lvl) begin
          state_d = ST_PULSE;
          wd_cause_d = 1'b0;
        end
      end
      ST_PULSE: begin
        if (uv_lvl) begin
          state_d = ST_HOLD;
          rp_cnt_d = 32'h0000_0000;
        end else if (rp_cnt_q >= rp_period_q - 32'h0000_0001) begin
          state_d = ST_RUN;
          rp_cnt_d = 32'h0000_0000;
        end else begin
          rp_cnt_d = rp_cnt_q + 32'h0000_0001;
        end
      end
      ST_RUN: begin
        rp_cnt_d = 32'h0000_0000;
        if (uv_lvl) begin
          state_d = ST_HOLD;
          wd_cause_d = 1'b0;
        end else if (wd_expire && !kick_edge && !mode_edge) begin
          state_d = ST_PULSE;
          wd_cause_d = 1'b1;
        end
      end
      default: begin
        state_d = ST_HOLD;
        rp_cnt_d = 32'h0000_0000;
        wd_cause_d = 1'b0;
      end
    endcase
  end

  // ------------------------------------------------------------
  // watchdog counter, next value
  // ------------------------------------------------------------
  always @* begin
    wd_cnt_d = wd_cnt_q + 32'h0000_0001;
    if (state_q != ST_RUN || state_d != ST_RUN) begin
      // restarts from zero after each pulse
      wd_cnt_d = 32'h0000_0000;
    end else if (kick_edge || mode_edge) begin
      wd_cnt_d = 32'h0000_0000;
    end else if (wd_keepalive || wd_off) begin
      wd_cnt_d = 32'h0000_0000;
    end
  end

  assign asserted_d = (state_d != ST_RUN);

  // ------------------------------------------------------------
  // sequencer and counter registers
  // ------------------------------------------------------------
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      state_q <= ST_HOLD;
      wd_cnt_q <= 32'h0000_0000;
      rp_cnt_q <= 32'h0000_0000;
      wd_cause_q <= 1'b0;
    end else begin
      state_q <= state_d;
      wd_cnt_q <= wd_cnt_d;
      rp_cnt_q <= rp_cnt_d;
      wd_cause_q <= wd_cause_d;
    end
  end

  // ------------------------------------------------------------
  // reset output pin
  // ------------------------------------------------------------
  // level and enable registered from the next state
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      reset_out <= 1'b0;
      reset_out_oe_n <= 1'b0;
    end else begin
      // active-low level is the exact inverse, active high passes through
      reset_out <= asserted_d ^ !ctrl_q[`SWR_CTRL_POL_HIGH];
      // open-drain drives only the low level
      if (ctrl_q[`SWR_CTRL_PUSH_PULL]) begin
        reset_out_oe_n <= 1'b0;
      end else begin
        reset_out_oe_n <= asserted_d ^ !ctrl_q[`SWR_CTRL_POL_HIGH];
      end
    end
  end

  // ------------------------------------------------------------
  // watchdog event counter
  // ------------------------------------------------------------
  // counts watchdog pulses, saturates, cleared by a status write
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      evt_cnt_q <= 8'h00;
    end else if (state_q == ST_RUN && state_d == ST_PULSE) begin
      if (evt_cnt_q != 8'hFF) begin
        evt_cnt_q <= evt_cnt_q + 8'h01;
      end
    end else if (bus_done && avs_write && avs_address == `SWR_OFS_STATUS) begin
      evt_cnt_q <= 8'h00;
    end
  end

  // ------------------------------------------------------------
  // avalon slave handshake
  // ------------------------------------------------------------
  assign bus_req = avs_read || avs_write;
  assign bus_done = bus_req && !avs_waitrequest;

  // one wait cycle, then a single cycle with waitrequest low
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0000_0000;
    end else if (bus_req && avs_waitrequest) begin
      avs_waitrequest <= 1'b0;
      avs_readdata <= avs_read ? rd_mux : 32'h0000_0000;
    end else begin
      avs_waitrequest <= 1'b1;
    end
  end

  // ------------------------------------------------------------
  // register writes
  // ------------------------------------------------------------
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      ctrl_q <= `SWR_CTRL_RST;
      wdt_set_q <= `SWR_WDT_SET_RST;
      rst_set_q <= `SWR_RST_SET_RST;
    end else if (bus_done && avs_write) begin
      case (avs_address)
        `SWR_OFS_CTRL: begin
          ctrl_q <= avs_writedata[1:0];
        end
        `SWR_OFS_WDT_SET: begin
          wdt_set_q <= avs_writedata[15:0];
        end
        `SWR_OFS_RST_SET: begin
          rst_set_q <= avs_writedata[15:0];
        end
        default: ctrl_q <= ctrl_q;
      endcase
    end
  end

  // ------------------------------------------------------------
  // read mux
  // ------------------------------------------------------------
  always @* begin
    rd_mux = 32'h0000_0000;
    case (avs_address)
      `SWR_OFS_CTRL: begin
        rd_mux[1:0] = ctrl_q;
      end
      `SWR_OFS_WDT_SET: begin
        rd_mux[15:0] = wdt_set_q;
      end
      `SWR_OFS_RST_SET: begin
        rd_mux[15:0] = rst_set_q;
      end
      `SWR_OFS_STATUS: begin
        rd_mux[`SWR_ST_RESET] = (state_q != ST_RUN);
        rd_mux[`SWR_ST_WD_CAUSE] = wd_cause_q;
        rd_mux[`SWR_ST_EXT_MODE] = mode_lvl;
        rd_mux[`SWR_ST_UNDRIVEN] = undriven_lvl;
        rd_mux[`SWR_ST_UNDERVOLT] = uv_lvl;
        rd_mux[`SWR_ST_WD_OFF] = wd_off;
        rd_mux[`SWR_ST_EVT_MSB:`SWR_ST_EVT_LSB] = evt_cnt_q;
      end
      default: begin
        rd_mux = 32'h0000_0000;
      end
    endcase
  end

endmodule

/* File: sim/swr_props.sv */
`timescale 1ns/1ps
// ----------------------------------------
// port checker
// ----------------------------------------
module swr_props (
  input wire sys_clk,
  input wire sys_rst,
  input wire [3:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire avs_waitrequest,
  input wire watchdog_kick_input,
  input wire watchdog_mode_select,
  input wire undervoltage,
  input wire reset_out,
  input wire reset_out_oe_n
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  reg pol_q, pp_q, kick_p, mode_p;
  reg [7:0] kc_q, mc_q, ac_q, uv_q, cq_q;
  reg [16:0] len_q;
  reg [31:0] rcyc_q;
  // reset as seen by the host, pull-up on the pin
  wire pin = reset_out_oe_n ? 1'b1 : reset_out;
  wire asrt = pol_q ? pin : !pin;
  wire wr_done = avs_write && !avs_waitrequest;
  wire ctl_wr = wr_done && avs_address == 4'h0;
  wire quiet = cq_q >= 8'h04;
  wire uv_low = uv_q >= 8'h08;
  function [7:0] nxt(input [7:0] c, input clr);
    nxt = clr ? 8'h00 : (c == 8'hFF ? c : c + 8'h01);
  endfunction
  // distances since kick, mode, reset, undervoltage and control writes
  always @(posedge sys_clk) begin
    kick_p <= watchdog_kick_input;
    mode_p <= watchdog_mode_select;
    kc_q <= nxt(kc_q, watchdog_kick_input != kick_p);
    mc_q <= nxt(mc_q, watchdog_mode_select != mode_p);
    ac_q <= nxt(ac_q, asrt);
    uv_q <= nxt(uv_q, undervoltage);
    cq_q <= nxt(cq_q, ctl_wr);
    len_q <= asrt ? (len_q == 17'h1FFFF ? len_q : len_q + 17'h00001) : 17'h00000;
    if (ctl_wr) begin
      pol_q <= avs_writedata[0];
      pp_q <= avs_writedata[1];
    end
    if (wr_done && avs_address == 4'h8) begin
      rcyc_q <= ({16'h0000, avs_writedata[15:0]} * 32'h00000A6E) / 32'h00000032;
    end
    if (sys_rst) begin
      pol_q <= 1'b0;
      pp_q <= 1'b0;
      kc_q <= 8'h00;
      mc_q <= 8'h00;
      ac_q <= 8'h00;
      uv_q <= 8'h00;
      cq_q <= 8'hFF;
      len_q <= 17'h00000;
      rcyc_q <= 32'h000138E4;
    end
  end
  chk_uv_held: assert property (undervoltage [*6] |-> asrt || !quiet)
    else $error("reset not held during undervoltage");
  chk_uv_tail: assert property ($fell(undervoltage) && quiet |-> asrt [*4])
    else $error("reset dropped with undervoltage");
  chk_pulse_min: assert property ($fell(asrt) && quiet |-> {15'h0000, len_q} >= rcyc_q)
    else $error("reset shorter than timeout");
  chk_od_drive: assert property (quiet && !pp_q |-> reset_out_oe_n || !reset_out)
    else $error("open drain drove high");
  chk_pp_drive: assert property (quiet && pp_q |-> !reset_out_oe_n)
    else $error("push pull not driving");
  chk_kick_gap: assert property ($rose(asrt) && quiet && uv_low |-> kc_q >= 8'h32)
    else $error("expiry too soon after kick");
  chk_mode_gap: assert property ($rose(asrt) && quiet && uv_low |-> mc_q >= 8'h32)
    else $error("expiry too soon after mode change");
  chk_rel_gap: assert property ($rose(asrt) && quiet && uv_low |-> ac_q >= 8'h32)
    else $error("expiry too soon after reset end");
  cov_read: cover property (avs_read && !avs_waitrequest);
  cov_wd_pulse: cover property ($rose(asrt) && uv_low);
  cov_uv_tail: cover property ($fell(undervoltage));
endmodule

bind supervisor_watchdog_reset swr_props u_swr_props (
  .sys_clk(sys_clk),
  .sys_rst(sys_rst),
  .avs_address(avs_address),
  .avs_read(avs_read),
  .avs_write(avs_write),
  .avs_writedata(avs_writedata),
  .avs_waitrequest(avs_waitrequest),
  .watchdog_kick_input(watchdog_kick_input),
  .watchdog_mode_select(watchdog_mode_select),
  .undervoltage(undervoltage),
  .reset_out(reset_out),
  .reset_out_oe_n(reset_out_oe_n)
);

/* File: sim/host_cpu_model.sv */
`timescale 1ns/1ps
// ----------------------------------------
// host processor model
// ----------------------------------------
module host_cpu_model #(
  parameter KICK_GAP = 20
) (
  input wire sys_clk,
  input wire reset_pin,
  input wire active_high,
  input wire kick_en,
  output reg watchdog_kick_input,
  output wire in_reset
);
  reg [7:0] gap_q;
  // reset decoded from pin and polarity
  assign in_reset = active_high ? reset_pin : !reset_pin;
  initial begin
    watchdog_kick_input = 1'b0;
    gap_q = 8'h00;
  end
  // kick before expiry
  // service loop, silent while held in reset
  always @(posedge sys_clk) begin
    if (!kick_en || in_reset) begin
      gap_q <= 8'h00;
    end else if (gap_q == KICK_GAP - 1) begin
      gap_q <= 8'h00;
      watchdog_kick_input <= !watchdog_kick_input;
    end else begin
      gap_q <= gap_q + 8'h01;
    end
  end
endmodule

/* File: sim/supervisor_watchdog_reset_tb_top.sv */
`timescale 1ns/1ps
module supervisor_watchdog_reset_tb_top;
  localparam int WD_CYC = 53;
  localparam int RST_CYC = 53;
  localparam int EXT_CYC = WD_CYC * 500;
  localparam int SLACK = 8;
  reg sys_clk = 1'b0;
  reg sys_rst = 1'b1;
  reg [3:0] avs_address = 4'h0;
  reg avs_read = 1'b0;
  reg avs_write = 1'b0;
  reg [31:0] avs_writedata = 32'h0;
  reg mode = 1'b0;
  reg undriven = 1'b0;
  reg uv = 1'b1;
  reg kick_en = 1'b0;
  reg pol = 1'b0;
  wire [31:0] avs_readdata;
  wire avs_waitrequest, kick, reset_out, reset_out_oe_n, in_reset;
  logic [31:0] rd;
  int err_total = 0;
  int n_checks = 0;
  int n, c;
  // pull-up on the reset pin
  wire pin = reset_out_oe_n ? 1'b1 : reset_out;
  always #25 sys_clk = !sys_clk;
  supervisor_watchdog_reset u_supervisor_watchdog_reset (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .watchdog_kick_input(kick),
    .watchdog_mode_select(mode), .kick_undriven(undriven), .undervoltage(uv),
    .reset_out(reset_out), .reset_out_oe_n(reset_out_oe_n));
  host_cpu_model u_host_cpu_model (.sys_clk(sys_clk), .reset_pin(pin), .active_high(pol),
    .kick_en(kick_en), .watchdog_kick_input(kick), .in_reset(in_reset));
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task chk_rng(input string nm, input int lo, input int hi, input int g);
    n_checks++;
    if (g < lo || g > hi) begin
      err_total++;
      $display("ERROR %s expected %0d..%0d seen %0d", nm, lo, hi, g);
    end
  endtask
  task bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    int k;
    @(posedge sys_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    k = 0;
    do begin
      @(posedge sys_clk);
      k++;
    end while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    chk_rng("bus_wait", 1, 49, k);
  endtask
  task wait_rst(input logic lvl, input int lim);
    n = 0;
    while (in_reset !== lvl && n < lim) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    // a wait that runs out ends the run as a failure
    if (in_reset !== lvl) begin
      err_total++;
      $display("ERROR reset_level expected %b seen %b", lvl, in_reset);
      summarize;
    end
  endtask
  task count_rst(input int cyc);
    c = 0;
    repeat (cyc) begin
      @(posedge sys_clk);
      #1;
      if (in_reset !== 1'b0) c++;
    end
  endtask
  task t_powerup;
    bus(0, 4'h0, 32'h0);
    chk("ctrl_rst", 32'h0, rd);
    bus(0, 4'h4, 32'h0);
    chk("wdt_rst", 32'h05DC, rd);
    bus(0, 4'h8, 32'h0);
    chk("rst_rst", 32'h05DC, rd);
    bus(1, 4'h2, 32'hFFFFFFFF);
    bus(0, 4'h2, 32'h0);
    chk("unmapped", 32'h0, rd);
    bus(0, 4'hC, 32'h0);
    chk("status_uv", 32'h11, rd & 32'h11);
    bus(1, 4'h4, 32'h1);
    bus(1, 4'h8, 32'h1);
    @(posedge sys_clk) uv <= 1'b0;
    kick_en <= 1'b1;
    wait_rst(0, 200);
    chk_rng("uv_release", RST_CYC, RST_CYC + SLACK, n);
  endtask
  task t_wd_pulse;
    count_rst(300);
    chk_rng("kicked", 0, 0, c);
    @(posedge sys_clk) kick_en <= 1'b0;
    wait_rst(1, 200);
    chk_rng("expiry", WD_CYC - 20, WD_CYC + SLACK, n);
    wait_rst(0, 200);
    chk_rng("wd_pulse", RST_CYC, RST_CYC + 1, n);
    wait_rst(1, 200);
    chk_rng("repeat", WD_CYC - 1, WD_CYC + SLACK, n);
    bus(0, 4'hC, 32'h0);
    chk("wd_count", 32'h0202, rd & 32'hFF02);
    @(posedge sys_clk) kick_en <= 1'b1;
    wait_rst(0, 200);
  endtask
  task t_ext_mode;
    repeat (100) @(posedge sys_clk);
    kick_en <= 1'b0;
    @(posedge sys_clk) mode <= 1'b1;
    wait_rst(1, 27000);
    chk_rng("ext_period", EXT_CYC, EXT_CYC + SLACK, n);
    wait_rst(0, 200);
    @(posedge sys_clk) undriven <= 1'b1;
    count_rst(30000);
    chk_rng("undriven", 0, 0, c);
    bus(0, 4'hC, 32'h0);
    chk("ext_status", 32'h0C, rd & 32'h0C);
    @(posedge sys_clk) undriven <= 1'b0;
    mode <= 1'b0;
    kick_en <= 1'b1;
    count_rst(60);
    chk_rng("mode_clear", 0, 0, c);
  endtask
  task t_polarity;
    bus(1, 4'h0, 32'h3);
    pol <= 1'b1;
    repeat (4) @(posedge sys_clk);
    #1;
    chk("pp_hi_idle", 32'h0, {30'h0, reset_out, reset_out_oe_n});
    @(posedge sys_clk) uv <= 1'b1;
    wait_rst(1, 20);
    chk_rng("uv_assert", 0, SLACK, n);
    count_rst(100);
    chk_rng("uv_held", 100, 100, c);
    chk("pp_hi_act", 32'h2, {30'h0, reset_out, reset_out_oe_n});
    @(posedge sys_clk) uv <= 1'b0;
    wait_rst(0, 200);
    chk_rng("uv_tail", RST_CYC, RST_CYC + SLACK, n);
    bus(1, 4'h0, 32'h0);
    pol <= 1'b0;
    repeat (4) @(posedge sys_clk);
    #1;
    chk("od_lo_idle", 32'h1, {31'h0, reset_out_oe_n});
  endtask
  task t_disable;
    bus(1, 4'h4, 32'h0);
    kick_en <= 1'b0;
    count_rst(400);
    chk_rng("wd_off", 0, 0, c);
    bus(0, 4'hC, 32'h0);
    chk("off_status", 32'h20, rd & 32'h20);
  endtask
  task summarize;
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // hang guard
  initial begin
    #(90000 * 50);
    err_total++;
    summarize;
  end
  // main sequence
  initial begin
    repeat (8) @(posedge sys_clk);
    sys_rst <= 1'b0;
    t_powerup;
    t_wd_pulse;
    t_ext_mode;
    t_polarity;
    t_disable;
    summarize;
  end
endmodule
